// ==== include/afec_consts.vh ====
`ifndef AFEC_CONSTS_VH
`define AFEC_CONSTS_VH

// register addresses on the serial port
`define AFEC_ADDR_CLAMP_TIMING 7'h02
`define AFEC_ADDR_GAIN_RANGE 7'h03
`define AFEC_ADDR_CLOCK_REF 7'h04
`define AFEC_ADDR_OUT_ENABLE 7'h05

// power-on values
`define AFEC_RST_CLAMP_TIMING 8'h9c
`define AFEC_RST_GAIN_RANGE 8'h00
`define AFEC_RST_CLOCK_REF 8'h00
`define AFEC_RST_OUT_ENABLE 8'h77

// writable bits per register
`define AFEC_WMASK_ALL 8'hff
`define AFEC_WMASK_GAIN_RANGE 8'h3f

// clamp_sample_timing_config fields
`define AFEC_CST_MODE_HI 7
`define AFEC_CST_SAMPLE_EDGE 6
`define AFEC_CST_HOLD_EDGE 5
`define AFEC_CST_STROBE_POL 4
`define AFEC_CST_PHASE_HI 3
`define AFEC_CST_PHASE_LO 2
`define AFEC_CST_MODE_LO 1
`define AFEC_CST_CLAMP_SRC 0

// input_gain_dac_range_config fields
`define AFEC_IGD_RANGE_HI 5
`define AFEC_IGD_RANGE_LO 3
`define AFEC_IGD_GAIN_HI 2
`define AFEC_IGD_GAIN_LO 0

// clock_clamp_reference_config fields
`define AFEC_CCR_DIVIDER_EN 7
`define AFEC_CCR_REF_PD 6
`define AFEC_CCR_CLAMP_EDGE 5
`define AFEC_CCR_RANGE_HI 3
`define AFEC_CCR_RANGE_LO 2
`define AFEC_CCR_SH3_DIS 1
`define AFEC_CCR_MULT 0

// channel_output_enable fields
`define AFEC_COE_EN_HI 2
`define AFEC_COE_EN_LO 0

// serial frame: 1 direction bit, 7 address bits, 8 data bits
`define AFEC_CNT_W 5
`define AFEC_CNT_ADDR_LAST 5'h07
`define AFEC_CNT_DATA_FIRST 5'h08
`define AFEC_CNT_DATA_LAST 5'h0f
`define AFEC_CNT_FULL 5'h10

`endif

// ==== core/afec_sync.v ====
module afec_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== core/afec_reg8.v ====
module afec_reg8 #(
  parameter [7:0] RESET = 8'h00,
  parameter [7:0] WMASK = 8'hff
) (
  input wire clk,
  input wire rst,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] q
);
  // bits outside the mask keep their reset value
  always @(posedge clk) begin
    if (rst) begin
      q <= RESET;
    end else if (we) begin
      q <= (wdata & WMASK) | (RESET & ~WMASK);
    end
  end
endmodule

// ==== core/afec_regs.v ====
// Summary of operation
// - bit 6 picks sample strobe capture edge
// - bit 5 picks hold strobe edge
// - bit 4 sets both strobe input polarities
// - phase bits 3:2; three-channel uses lower only
// - bit 0 picks clamp source
// - sampling mode from three joint bits
// - clock register bit 1 disables third mode
// - bits 5:3 fine DAC range per colour
// - bits 2:0 input gain per colour
// - clock register bit 7 enables divider
// - bit 6 powers down reference buffers only
// - bit 5 picks clamp input sampling edge
// - bits 3:2 select internal clock range
// - transfer and converter clocks share frequency
// - bit 0 selects two or three times
// - output enable bits per colour
// - input mode picks three or six channels
`include "afec_consts.vh"

module afec_regs (
  input wire clk,
  input wire rst,
  input wire serial_clock,
  input wire serial_enable_n,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_out_oe,
  input wire six_channel_mode,
  input wire reference_sample_strobe,
  input wire data_sample_strobe,
  input wire external_clamp_input,
  output reg sample_capture,
  output reg hold_capture,
  output reg clamp_active,
  output reg clamp_sample_falling,
  output reg [1:0] front_end_phase_setting,
  output reg [2:0] sampling_mode_code,
  output reg third_sample_hold_mode_en,
  output reg [2:0] fine_offset_dac_wide_range,
  output reg [2:0] input_gain_high,
  output reg external_clamp_voltage_divider_en,
  output reg reference_buffer_powerdown,
  output reg [1:0] clock_range_select,
  output reg transfer_clock_mult_sel,
  output reg converter_clock_mult_sel,
  output reg [2:0] channel_output_en
);
  wire sclk_s;
  wire frame_s;
  wire sdi_s;
  wire ref_strobe_s;
  wire data_strobe_s;
  wire ext_clamp_s;

  // enable synced inverted so the reset value reads as idle
  afec_sync #(
    .W(6)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({serial_clock, ~serial_enable_n, serial_data_in,
        reference_sample_strobe, data_sample_strobe, external_clamp_input}),
    .q({sclk_s, frame_s, sdi_s, ref_strobe_s, data_strobe_s, ext_clamp_s})
  );

  // serial frame decode
  reg sclk_d;
  reg [`AFEC_CNT_W-1:0] bit_cnt;
  reg [6:0] shift_in;
  reg cmd_read;
  reg [6:0] cmd_addr;
  reg [7:0] shift_out;
  wire sclk_rise;
  wire sclk_fall;
  wire frame;
  wire [7:0] in_byte;

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign frame = frame_s;
  assign in_byte = {shift_in, sdi_s};

  wire [7:0] r_clamp_timing;
  wire [7:0] r_gain_range;
  wire [7:0] r_clock_ref;
  wire [7:0] r_out_enable;
  reg [7:0] read_data;

  always @* begin
    case (in_byte[6:0])
      `AFEC_ADDR_CLAMP_TIMING: read_data = r_clamp_timing;
      `AFEC_ADDR_GAIN_RANGE: read_data = r_gain_range;
      `AFEC_ADDR_CLOCK_REF: read_data = r_clock_ref;
      `AFEC_ADDR_OUT_ENABLE: read_data = r_out_enable;
      default: read_data = 8'h00;
    endcase
  end

  wire write_hit;
  assign write_hit = frame & sclk_rise & ~cmd_read & (bit_cnt == `AFEC_CNT_DATA_LAST);

  always @(posedge clk) begin
    if (rst) begin
      sclk_d <= 1'b0;
      bit_cnt <= {`AFEC_CNT_W{1'b0}};
      shift_in <= 7'h00;
      cmd_read <= 1'b0;
      cmd_addr <= 7'h00;
      shift_out <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      if (!frame) begin
        bit_cnt <= {`AFEC_CNT_W{1'b0}};
        cmd_read <= 1'b0;
        serial_data_out_oe <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt != `AFEC_CNT_FULL) begin
          shift_in <= in_byte[6:0];
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == `AFEC_CNT_ADDR_LAST) begin
            cmd_read <= in_byte[7];
            cmd_addr <= in_byte[6:0];
            shift_out <= read_data;
          end
        end
        // read data leaves on falling edges, msb first
        if (sclk_fall && cmd_read && bit_cnt >= `AFEC_CNT_DATA_FIRST
            && bit_cnt != `AFEC_CNT_FULL) begin
          serial_data_out <= shift_out[7];
          serial_data_out_oe <= 1'b1;
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  afec_reg8 #(
    .RESET(`AFEC_RST_CLAMP_TIMING),
    .WMASK(`AFEC_WMASK_ALL)
  ) u_clamp_timing (
    .clk(clk),
    .rst(rst),
    .we(write_hit && cmd_addr == `AFEC_ADDR_CLAMP_TIMING),
    .wdata(in_byte),
    .q(r_clamp_timing)
  );

  afec_reg8 #(
    .RESET(`AFEC_RST_GAIN_RANGE),
    .WMASK(`AFEC_WMASK_GAIN_RANGE)
  ) u_gain_range (
    .clk(clk),
    .rst(rst),
    .we(write_hit && cmd_addr == `AFEC_ADDR_GAIN_RANGE),
    .wdata(in_byte),
    .q(r_gain_range)
  );

  afec_reg8 #(
    .RESET(`AFEC_RST_CLOCK_REF),
    .WMASK(`AFEC_WMASK_ALL)
  ) u_clock_ref (
    .clk(clk),
    .rst(rst),
    .we(write_hit && cmd_addr == `AFEC_ADDR_CLOCK_REF),
    .wdata(in_byte),
    .q(r_clock_ref)
  );

  // upper bits stored as written; host keeps them at default
  afec_reg8 #(
    .RESET(`AFEC_RST_OUT_ENABLE),
    .WMASK(`AFEC_WMASK_ALL)
  ) u_out_enable (
    .clk(clk),
    .rst(rst),
    .we(write_hit && cmd_addr == `AFEC_ADDR_OUT_ENABLE),
    .wdata(in_byte),
    .q(r_out_enable)
  );

  // strobe polarity normalisation and edge capture
  reg ref_act_d;
  reg data_act_d;
  wire ref_act;
  wire data_act;
  wire ref_pol;

  assign ref_pol = r_clamp_timing[`AFEC_CST_STROBE_POL];
  assign ref_act = ref_strobe_s ~^ ref_pol;
  assign data_act = data_strobe_s ~^ ref_pol;

  reg next_sample;
  reg next_hold;

  always @* begin
    if (r_clamp_timing[`AFEC_CST_SAMPLE_EDGE]) begin
      next_sample = ~ref_act & ref_act_d;
    end else begin
      next_sample = ref_act & ~ref_act_d;
    end
    if (r_clamp_timing[`AFEC_CST_HOLD_EDGE]) begin
      next_hold = ~data_act & data_act_d;
    end else begin
      next_hold = data_act & ~data_act_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ref_act_d <= 1'b0;
      data_act_d <= 1'b0;
      sample_capture <= 1'b0;
      hold_capture <= 1'b0;
      clamp_active <= 1'b0;
    end else begin
      ref_act_d <= ref_act;
      data_act_d <= data_act;
      sample_capture <= next_sample;
      hold_capture <= next_hold;
      if (r_clamp_timing[`AFEC_CST_CLAMP_SRC]) begin
        clamp_active <= next_sample;
      end else begin
        clamp_active <= ext_clamp_s;
      end
    end
  end

  // field decode to the analog controls
  always @(posedge clk) begin
    if (rst) begin
      clamp_sample_falling <= 1'b0;
      front_end_phase_setting <= 2'h0;
      sampling_mode_code <= 3'h0;
      third_sample_hold_mode_en <= 1'b0;
      fine_offset_dac_wide_range <= 3'h0;
      input_gain_high <= 3'h0;
      external_clamp_voltage_divider_en <= 1'b0;
      reference_buffer_powerdown <= 1'b0;
      clock_range_select <= 2'h0;
      transfer_clock_mult_sel <= 1'b0;
      converter_clock_mult_sel <= 1'b0;
      channel_output_en <= 3'h0;
    end else begin
      clamp_sample_falling <= r_clock_ref[`AFEC_CCR_CLAMP_EDGE];
      front_end_phase_setting <= {
        r_clamp_timing[`AFEC_CST_PHASE_HI] & six_channel_mode,
        r_clamp_timing[`AFEC_CST_PHASE_LO]};
      sampling_mode_code <= {
        r_clamp_timing[`AFEC_CST_MODE_HI],
        r_clamp_timing[`AFEC_CST_MODE_LO],
        r_clock_ref[`AFEC_CCR_SH3_DIS]};
      third_sample_hold_mode_en <= ~r_clock_ref[`AFEC_CCR_SH3_DIS];
      fine_offset_dac_wide_range <=
        r_gain_range[`AFEC_IGD_RANGE_HI:`AFEC_IGD_RANGE_LO];
      input_gain_high <= r_gain_range[`AFEC_IGD_GAIN_HI:`AFEC_IGD_GAIN_LO];
      external_clamp_voltage_divider_en <= r_clock_ref[`AFEC_CCR_DIVIDER_EN];
      reference_buffer_powerdown <= r_clock_ref[`AFEC_CCR_REF_PD];
      clock_range_select <= r_clock_ref[`AFEC_CCR_RANGE_HI:`AFEC_CCR_RANGE_LO];
      // one select feeds both clocks so they never differ
      transfer_clock_mult_sel <= r_clock_ref[`AFEC_CCR_MULT];
      converter_clock_mult_sel <= r_clock_ref[`AFEC_CCR_MULT];
      channel_output_en <= r_out_enable[`AFEC_COE_EN_HI:`AFEC_COE_EN_LO];
    end
  end
endmodule

// ==== bench/afec_regs_sva.sv ====
module afec_regs_sva (
  input wire clk,
  input wire rst,
  input wire serial_enable_n,
  input wire six_channel_mode,
  input wire reference_sample_strobe,
  input wire data_sample_strobe,
  input wire sample_capture,
  input wire hold_capture,
  input wire [1:0] front_end_phase_setting,
  input wire [2:0] sampling_mode_code,
  input wire third_sample_hold_mode_en,
  input wire [2:0] input_gain_high,
  input wire [1:0] clock_range_select,
  input wire transfer_clock_mult_sel,
  input wire converter_clock_mult_sel,
  input wire [2:0] channel_output_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // pin edge three clocks back, past the synchronisers
  sequence s_pin_edge(x);
    $past(x, 3) != $past(x, 4);
  endsequence
  sequence s_idle;
    serial_enable_n [*6];
  endsequence
  // a polarity write inside a frame may also make an edge
  a_sample_cause: assert property (
    sample_capture |-> s_pin_edge(reference_sample_strobe) or !serial_enable_n)
    else $error("sample pulse without strobe edge");
  a_hold_cause: assert property (
    hold_capture |-> s_pin_edge(data_sample_strobe) or !serial_enable_n)
    else $error("hold pulse without strobe edge");
  a_sample_one_cycle: assert property (sample_capture |=> !sample_capture)
    else $error("sample pulse longer than one cycle");
  a_reset_defaults: assert property ($fell(rst) |=> channel_output_en == 3'b111
    && sampling_mode_code == 3'b100 && clock_range_select == 2'b00)
    else $error("outputs differ from power-on values");
  a_sh3_inverse: assert property (
    !$past(rst) |-> third_sample_hold_mode_en != sampling_mode_code[0])
    else $error("third mode enable not inverse of its bit");
  a_mult_shared: assert property (transfer_clock_mult_sel == converter_clock_mult_sel)
    else $error("transfer and converter multipliers differ");
  a_phase_upper: assert property (
    !$past(six_channel_mode) |-> !front_end_phase_setting[1])
    else $error("upper phase bit used in three channel mode");
  a_cfg_stable: assert property (
    s_idle |-> $stable(channel_output_en) && $stable(input_gain_high))
    else $error("configuration changed outside a frame");
endmodule

// ==== bench/afec_host.sv ====
`include "afec_consts.vh"
module afec_host (
  input wire clk,
  input wire serial_data_out,
  input wire serial_data_out_oe,
  output logic serial_clock,
  output logic serial_enable_n,
  output logic serial_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] OE_DEF = `AFEC_RST_OUT_ENABLE;
  initial begin
    serial_clock = 1'b0;
    serial_enable_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  // frame of nb bits, msb first; nb below 16 aborts it
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
      input int nb, output logic [7:0] rd);
    logic [15:0] f;
    f = {rw, a, wd};
    if (!rw && a == 7'h05) f[7:3] = OE_DEF[7:3];
    rd = 8'h00;
    serial_enable_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      serial_data_in = f[15-i];
      half();
      if (i > 7) rd = {rd[6:0], serial_data_out_oe ? serial_data_out : 1'bx};
      serial_clock = 1'b1;
      half();
      serial_clock = 1'b0;
    end
    half();
    serial_enable_n = 1'b1;
    serial_data_in = ~serial_data_in;
    half();
  endtask
endmodule

// ==== bench/tb_afec_regs.sv ====
module tb_afec_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, six_channel_mode = 1'b1, external_clamp_input = 1'b1;
  logic reference_sample_strobe = 1'b0, data_sample_strobe = 1'b0;
  logic serial_clock, serial_enable_n, serial_data_in, serial_data_out, serial_data_out_oe;
  logic sample_capture, hold_capture, clamp_active, clamp_sample_falling;
  logic third_sample_hold_mode_en, external_clamp_voltage_divider_en;
  logic reference_buffer_powerdown, transfer_clock_mult_sel, converter_clock_mult_sel;
  logic [1:0] front_end_phase_setting, clock_range_select;
  logic [2:0] sampling_mode_code, fine_offset_dac_wide_range, input_gain_high;
  logic [2:0] channel_output_en;
  logic [7:0] d, ns = 8'h00, nh = 8'h00, nc = 8'h00;
  int err_total = 0, tests_run = 0, cyc = 0;
  localparam logic [6:0] RA [5] = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h06};
  localparam logic [7:0] RV [5] = '{8'h9c, 8'h00, 8'h00, 8'h77, 8'h00};
  localparam logic [7:0] RW [5] = '{8'h63, 8'h3f, 8'hff, 8'h70, 8'h00};
  localparam logic [7:0] CFG [4] = '{8'h9c, 8'hdc, 8'hbd, 8'h8c};
  localparam logic [3:0] ES = 4'b0101;
  localparam logic [3:0] EH = 4'b0011;
  afec_regs u_afec_regs (.*);
  afec_host u_afec_host (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (sample_capture === 1'b1) ns++;
    if (hold_capture === 1'b1) nh++;
    if (clamp_active === 1'b1) nc++;
    if (cyc == 12000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_afec_host.xfer(1'b0, a, v, 16, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    u_afec_host.xfer(1'b1, a, 8'h00, 16, d);
    chk("readback", e, d);
  endtask
  task automatic wrap_up();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("out_en", 8'h07, channel_output_en);
    chk("phase", 8'h03, front_end_phase_setting);
    for (int i = 0; i < 5; i++) rd(RA[i], RV[i]);
    $display("test defaults done");
    wr(7'h02, 8'h63);
    wr(7'h03, 8'hff);
    wr(7'h04, 8'hff);
    wr(7'h05, 8'hf8);
    wr(7'h06, 8'h55);
    u_afec_host.xfer(1'b0, 7'h05, 8'h77, 12, d);
    for (int i = 0; i < 5; i++) rd(RA[i], RW[i]);
    chk("mode", 8'h03, {third_sample_hold_mode_en, sampling_mode_code});
    chk("analog", 8'h3f, {fine_offset_dac_wide_range, input_gain_high});
    chk("ref", 8'h07, {external_clamp_voltage_divider_en, reference_buffer_powerdown,
      clamp_sample_falling});
    chk("clock", 8'h0f, {clock_range_select, transfer_clock_mult_sel,
      converter_clock_mult_sel});
    chk("out_en", 8'h00, channel_output_en);
    wr(7'h04, 8'h05);
    wr(7'h05, 8'h75);
    chk("clock", 8'h07, {clock_range_select, transfer_clock_mult_sel,
      converter_clock_mult_sel});
    chk("mode", 8'h0a, {third_sample_hold_mode_en, sampling_mode_code});
    chk("out_en", 8'h05, channel_output_en);
    $display("test writes done");
    for (int i = 0; i < 4; i++) begin
      wr(7'h02, CFG[i]);
      repeat (6) @(negedge clk);
      ns = 8'h00;
      nh = 8'h00;
      nc = 8'h00;
      {reference_sample_strobe, data_sample_strobe, external_clamp_input} = 3'b111;
      repeat (8) @(negedge clk);
      chk("sample_rise", ES[i], ns);
      chk("hold_rise", EH[i], nh);
      if (CFG[i][0])
        chk("clamp_pulse", ES[i], nc);
      else
        chk("clamp", 8'h01, clamp_active);
      ns = 8'h00;
      nh = 8'h00;
      nc = 8'h00;
      {reference_sample_strobe, data_sample_strobe, external_clamp_input} = 3'b000;
      repeat (8) @(negedge clk);
      chk("sample_fall", !ES[i], ns);
      chk("hold_fall", !EH[i], nh);
      if (CFG[i][0])
        chk("clamp_pulse", !ES[i], nc);
      else
        chk("clamp", 8'h00, clamp_active);
      $display("test strobe %h done", CFG[i]);
    end
    six_channel_mode = 1'b0;
    repeat (4) @(negedge clk);
    chk("phase", 8'h01, front_end_phase_setting);
    six_channel_mode = 1'b1;
    repeat (4) @(negedge clk);
    chk("phase", 8'h03, front_end_phase_setting);
    $display("test phase done");
    wrap_up();
  end
endmodule
bind afec_regs afec_regs_sva u_afec_regs_sva (.*);
